// ---- design/modem_frame_config_ab.sv ----
// Modem frame configuration registers with transmit sequencing, receive timeouts and A/D reference control.
//
// Local design decision: the APB register port.
`timescale 1ns/100ps

module modem_frame_config_ab
    import modem_cfg_pkg::*;
#(
    parameter int REF_W = 6
) (
    // System
    input  wire logic             clk_sys,
    input  wire logic             sys_rst,
    // APB slave
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [7:0]       paddr,
    input  wire logic [31:0]      pwdata,
    output logic                  pready,
    output logic                  pslverr,
    output logic [31:0]           prdata,
    // Bit clocks from the clock generator
    input  wire logic             transmit_bit_clock,
    input  wire logic             receive_bit_clock,
    // Transmit side
    input  wire logic             tx_enable,
    output logic                  tx_data_req,
    output logic                  tx_in_header,
    output logic                  qpsk_rate,
    // Receive side
    input  wire logic             acq_done,
    input  wire logic             sfd_found,
    input  wire logic             rx_len_valid,
    input  wire logic [15:0]      rx_len,
    input  wire logic             rx_dqpsk,
    output logic                  rx_to_acq,
    // A/D reference calibration
    input  wire logic             ref_up,
    input  wire logic             ref_down,
    output logic [REF_W-1:0]      adc_ref
);

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    cfg_a_type        cfg_a_ff;
    cfg_b_type        cfg_b_ff;
    logic             acc_wr;
    logic [31:0]      nxt_rdata;

    typedef enum logic [2:0] {
        RX_ACQ  = 3'b001,
        RX_SFD  = 3'b010,
        RX_DATA = 3'b100
    } rx_state_type;

    rx_state_type     rx_state_ff;
    logic             tx_busy_ff;

    // No register access needs a wait state, so the slave answers at once.
    // Status is read-only; a write to it is dropped without an error.
    assign pready  = 1'b1;
    assign acc_wr  = psel && penable && pwrite;
    assign pslverr = psel && penable && (paddr != OFS_CONFIG_A) && (paddr != OFS_CONFIG_B)
                     && (paddr != OFS_STATUS);

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            cfg_a_ff <= cfg_a_type'(RST_CONFIG_A[4:1]);
            cfg_b_ff <= cfg_b_type'(RST_CONFIG_B);
        end else if (acc_wr) begin
            if (paddr == OFS_CONFIG_A) begin
                // Bit 0 is not stored, so it can never alter behaviour.
                cfg_a_ff <= cfg_a_type'(pwdata[4:1]);
            end
            if (paddr == OFS_CONFIG_B) begin
                cfg_b_ff <= cfg_b_type'(pwdata[7:0]);
            end
        end
    end

    always_comb begin
        nxt_rdata = 32'h0000_0000;
        if (paddr == OFS_CONFIG_A) begin
            nxt_rdata[4:1] = cfg_a_ff;
        end else if (paddr == OFS_CONFIG_B) begin
            nxt_rdata[7:0] = cfg_b_ff;
        end else if (paddr == OFS_STATUS) begin
            nxt_rdata[2:0]            = rx_state_ff;
            nxt_rdata[3]              = tx_busy_ff;
            nxt_rdata[8 +: REF_W]     = adc_ref;
        end
    end

    // Read data is captured in the setup phase so that it stands for the
    // whole access phase without a wait state.
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= nxt_rdata;
        end
    end

    // ------------------------------------------------------------
    // Bit clock synchronisers and edge detection
    // ------------------------------------------------------------
    // Three stages; a level change is accepted only when stages two
    // and three agree, which rejects a single metastable sample.
    logic [1:0]       clk_pin;
    logic [1:0]       s1_ff;
    logic [1:0]       s2_ff;
    logic [1:0]       s3_ff;
    logic [1:0]       lvl_ff;
    logic [1:0]       rise;

    assign clk_pin = {receive_bit_clock, transmit_bit_clock};

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_sync
            always_ff @(posedge clk_sys) begin
                if (sys_rst) begin
                    s1_ff[gi]  <= 1'b0;
                    s2_ff[gi]  <= 1'b0;
                    s3_ff[gi]  <= 1'b0;
                    lvl_ff[gi] <= 1'b0;
                end else begin
                    s1_ff[gi] <= clk_pin[gi];
                    s2_ff[gi] <= s1_ff[gi];
                    s3_ff[gi] <= s2_ff[gi];
                    if (s2_ff[gi] == s3_ff[gi]) begin
                        lvl_ff[gi] <= s3_ff[gi];
                    end
                end
            end
            assign rise[gi] = (s2_ff[gi] == s3_ff[gi]) && s3_ff[gi] && !lvl_ff[gi];
        end
    endgenerate

    // ------------------------------------------------------------
    // Transmit header sequencing
    // ------------------------------------------------------------
    function automatic logic [15:0] hdr_bits(input hdr_mode_type m);
        logic [15:0] b;
        b = PREAMBLE_BITS + SFD_BITS;
        case (m)
            HDR_SFD_ONLY: b = b;
            HDR_SFD_CRC:  b = b + CRC_BITS;
            HDR_SFD_LEN:  b = b + LENGTH_BITS + CRC_BITS;
            HDR_FULL:     b = b + SIG_SRV_BITS + LENGTH_BITS + CRC_BITS;
            default:      b = b;
        endcase
        return b;
    endfunction

    logic [16:0]      rem_ff;
    logic             tx_en_d_ff;
    logic [16:0]      nxt_rem;

    // Header bits are BPSK; at constant rate the clock runs at the QPSK
    // rate, so every header bit spans two bit clock periods.
    always_comb begin
        nxt_rem = {1'b0, hdr_bits(cfg_a_ff.hdr_mode)};
        if (cfg_b_ff.const_rate) begin
            nxt_rem = {hdr_bits(cfg_a_ff.hdr_mode), 1'b0};
        end
    end

    // A bit clock edge seen in the load cycle is not counted; the host
    // must start the clock only after it raises the transmit enable.
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            tx_busy_ff <= 1'b0;
            tx_en_d_ff <= 1'b0;
            rem_ff     <= 17'h0_0000;
        end else begin
            tx_en_d_ff <= tx_enable;
            if (!tx_enable) begin
                tx_busy_ff <= 1'b0;
                rem_ff     <= 17'h0_0000;
            end else if (!tx_en_d_ff) begin
                tx_busy_ff <= 1'b1;
                rem_ff     <= nxt_rem;
            end else if (rise[0] && rem_ff != 17'h0_0000) begin
                rem_ff <= rem_ff - 17'h0_0001;
            end
        end
    end

    // The request stands from N periods before data until the host drops
    // the transmit enable; a lead longer than the header raises it at once.
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            tx_data_req <= 1'b0;
        end else if (!tx_enable) begin
            tx_data_req <= 1'b0;
        end else if (tx_busy_ff && rem_ff <= {12'h000, cfg_b_ff.lead_cnt}) begin
            tx_data_req <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            tx_in_header <= 1'b0;
        end else begin
            tx_in_header <= tx_busy_ff && (rem_ff != 17'h0_0000);
        end
    end

    // Rate indication to the bit clock generator: fixed at QPSK in
    // constant-rate operation, else QPSK only for DQPSK receive data.
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            qpsk_rate <= 1'b0;
        end else if (cfg_b_ff.const_rate) begin
            qpsk_rate <= 1'b1;
        end else begin
            qpsk_rate <= rx_dqpsk && (rx_state_ff == RX_DATA);
        end
    end

    // ------------------------------------------------------------
    // Receive timeouts
    // ------------------------------------------------------------
    logic [15:0]      sfd_cnt_ff;
    logic [15:0]      len_cnt_ff;
    logic [15:0]      len_ff;
    logic             len_armed_ff;
    logic             len_mode;
    logic             abort;

    assign len_mode = (cfg_a_ff.hdr_mode == HDR_SFD_LEN) || (cfg_a_ff.hdr_mode == HDR_FULL);

    // A zero length ends the frame as soon as the length is known, before
    // any data bit edge, and does not depend on either timeout enable.
    always_comb begin
        abort = 1'b0;
        case (rx_state_ff)
            RX_SFD:  abort = cfg_a_ff.sfd_tmr_en && !sfd_found && (sfd_cnt_ff >= SFD_TMO_BITS);
            RX_DATA: abort = (rx_len_valid && rx_len == 16'h0000)
                             || (len_armed_ff && rise[1] && len_cnt_ff + 16'h0001 >= len_ff);
            default: abort = 1'b0;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            rx_state_ff <= RX_ACQ;
            sfd_cnt_ff  <= 16'h0000;
        end else begin
            case (rx_state_ff)
                RX_ACQ: begin
                    sfd_cnt_ff <= 16'h0000;
                    if (acq_done) begin
                        rx_state_ff <= RX_SFD;
                    end
                end
                RX_SFD: begin
                    if (abort) begin
                        rx_state_ff <= RX_ACQ;
                    end else if (sfd_found) begin
                        rx_state_ff <= RX_DATA;
                    end else if (cfg_a_ff.sfd_tmr_en && rise[1]) begin
                        sfd_cnt_ff <= sfd_cnt_ff + 16'h0001;
                    end
                end
                RX_DATA: begin
                    if (abort) begin
                        rx_state_ff <= RX_ACQ;
                    end
                end
                default: rx_state_ff <= RX_ACQ;
            endcase
        end
    end

    // Counting starts from the edge after the length is known, so a stray
    // bit clock edge in the delimiter search never counts as data.
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            len_armed_ff <= 1'b0;
            len_cnt_ff   <= 16'h0000;
            len_ff       <= 16'h0000;
        end else if (rx_state_ff != RX_DATA || abort) begin
            len_armed_ff <= 1'b0;
            len_cnt_ff   <= 16'h0000;
        end else if (rx_len_valid) begin
            len_ff       <= rx_len;
            len_armed_ff <= cfg_a_ff.len_to_en && len_mode;
            len_cnt_ff   <= 16'h0000;
        end else if (len_armed_ff && rise[1]) begin
            len_cnt_ff <= len_cnt_ff + 16'h0001;
        end
    end

    // Registered so that the acquisition request is a single clean pulse
    // which the receive front end can use without further qualification.
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            rx_to_acq <= 1'b0;
        end else begin
            rx_to_acq <= abort;
        end
    end

    // ------------------------------------------------------------
    // A/D reference calibration
    // ------------------------------------------------------------
    localparam logic [REF_W-1:0] REF_MID = {1'b1, {(REF_W-1){1'b0}}};
    localparam logic [REF_W-1:0] REF_MAX = {REF_W{1'b1}};

    // Fix has priority over hold, so a held value never masks mid-scale.
    // Up and down requests together cancel, so a noisy level detector
    // cannot make the reference dither on every clock.
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            adc_ref <= REF_MID;
        end else if (cfg_b_ff.ref_fix) begin
            adc_ref <= REF_MID;
        end else if (cfg_b_ff.ref_hold) begin
            adc_ref <= adc_ref;
        end else if (ref_up && !ref_down && adc_ref != REF_MAX) begin
            adc_ref <= adc_ref + 1'b1;
        end else if (ref_down && !ref_up && adc_ref != '0) begin
            adc_ref <= adc_ref - 1'b1;
        end
    end

endmodule

// ---- design/modem_cfg_pkg.sv ----
// Package with register map, field layout and timing constants of the modem frame block.
package modem_cfg_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CONFIG_A = 8'h00;
    localparam logic [7:0] OFS_CONFIG_B = 8'h04;
    localparam logic [7:0] OFS_STATUS   = 8'h08;
    localparam logic [7:0] RST_CONFIG_A = 8'h00;
    localparam logic [7:0] RST_CONFIG_B = 8'h00;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int POS_HDR_MODE   = 3;
    localparam int POS_SFD_TMR_EN = 2;
    localparam int POS_LEN_TO_EN  = 1;
    localparam int POS_CONST_RATE = 7;
    localparam int POS_LEAD_CNT   = 2;
    localparam int POS_REF_FIX    = 1;
    localparam int POS_REF_HOLD   = 0;

    // ------------------------------------------------------------
    // Frame field lengths and the delimiter timeout in bits
    // ------------------------------------------------------------
    localparam logic [15:0] PREAMBLE_BITS = 16'h0080;
    localparam logic [15:0] SFD_BITS      = 16'h0010;
    localparam logic [15:0] LENGTH_BITS   = 16'h0010;
    localparam logic [15:0] CRC_BITS      = 16'h0010;
    localparam logic [15:0] SIG_SRV_BITS  = 16'h0010;
    localparam logic [15:0] SFD_TMO_BITS  = 16'h0100;

    typedef enum logic [1:0] {
        HDR_SFD_ONLY = 2'h0,
        HDR_SFD_CRC  = 2'h1,
        HDR_SFD_LEN  = 2'h2,
        HDR_FULL     = 2'h3
    } hdr_mode_type;

    typedef struct packed {
        hdr_mode_type hdr_mode;
        logic         sfd_tmr_en;
        logic         len_to_en;
    } cfg_a_type;

    typedef struct packed {
        logic       const_rate;
        logic [4:0] lead_cnt;
        logic       ref_fix;
        logic       ref_hold;
    } cfg_b_type;

endpackage

// ---- verification/bit_clock_host_model.sv ----
// Far-side host model that runs the bit clock during a frame and counts its rising edges.
`timescale 1ns/100ps
module bit_clock_host_model (
    // Control from the bench
    input  wire logic run,
    // Bit clock toward the block, edge count toward the bench
    output logic      bclk,
    output int        edges
);
    // --------------------
    // Clock generation
    // --------------------
    // The 1 ns offset keeps bit clock edges off the system clock edges, so edge counts never race.
    // The clock stands still at low outside a frame, as a real host would leave it.
    initial begin
        bclk = 1'b0;
        edges = 0;
        #1;
        forever begin
            #32;
            if (run) begin
                bclk = ~bclk;
                edges = edges + int'(bclk);
            end else begin
                bclk = 1'b0;
                edges = 0;
            end
        end
    end
endmodule

// ---- verification/modem_frame_config_ab_assertions.sv ----
// Assertion checker for the modem frame configuration block, bound to its ports.
`timescale 1ns/100ps
module modem_frame_config_ab_assertions
    import modem_cfg_pkg::*;
#(
    parameter int REF_W = 6
) (
    // System and register bus
    input wire logic             clk_sys,
    input wire logic             sys_rst,
    input wire logic             psel,
    input wire logic             penable,
    input wire logic             pwrite,
    input wire logic [7:0]       paddr,
    input wire logic [31:0]      pwdata,
    input wire logic [31:0]      prdata,
    // Transmit and receive
    input wire logic             tx_enable,
    input wire logic             tx_data_req,
    input wire logic             tx_in_header,
    input wire logic             qpsk_rate,
    input wire logic             rx_len_valid,
    input wire logic [15:0]      rx_len,
    input wire logic             rx_to_acq,
    // Reference control
    input wire logic             ref_up,
    input wire logic             ref_down,
    input wire logic [REF_W-1:0] adc_ref
);
    // --------------------
    // Shadow and checks
    // --------------------
    localparam logic [REF_W-1:0] MID = {1'b1, {(REF_W-1){1'b0}}};
    logic [7:0] cfg_b_ff;
    logic       acc;
    assign acc = psel && penable;
    // The shadow copy lets the checks see settings without reaching into the block.
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            cfg_b_ff <= RST_CONFIG_B;
        end else if (acc && pwrite && paddr == OFS_CONFIG_B) begin
            cfg_b_ff <= pwdata[7:0];
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    chk_ref_fix_mid: assert property (cfg_b_ff[1] |=> adc_ref == MID)
        else $error("reference not at mid-scale");
    chk_ref_hold_frozen: assert property (cfg_b_ff[1:0] == 2'h1 |=> $stable(adc_ref))
        else $error("held reference moved");
    chk_ref_step_up: assert property (cfg_b_ff[1:0] == 2'h0 && ref_up && !ref_down && adc_ref != '1
        |=> adc_ref == $past(adc_ref) + 1'b1) else $error("reference did not step up");
    chk_bit0_unused: assert property (acc && !pwrite && paddr == OFS_CONFIG_A |-> !prdata[0])
        else $error("unused bit reads back set");
    chk_lead_readback: assert property (acc && !pwrite && paddr == OFS_CONFIG_B |-> prdata[7:0] == cfg_b_ff)
        else $error("second register readback wrong");
    chk_const_rate: assert property (cfg_b_ff[7] |=> qpsk_rate)
        else $error("rate not held at QPSK");
    chk_req_release: assert property (!tx_enable |=> !tx_data_req)
        else $error("data request outlived frame");
    chk_zero_len: assert property (rx_len_valid && rx_len == 16'h0000 |=> rx_to_acq)
        else $error("zero length did not abort");
    chk_acq_pulse: assert property (rx_to_acq |=> !rx_to_acq)
        else $error("abort pulse too long");
    chk_hdr_start: assert property ($rose(tx_enable) |-> ##[1:3] tx_in_header)
        else $error("header did not start");
    cover property ($rose(tx_data_req));
    cover property (rx_to_acq);
    cover property ($fell(tx_in_header));
endmodule

bind modem_frame_config_ab modem_frame_config_ab_assertions #(.REF_W(REF_W)) i_chk (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .tx_enable(tx_enable),
    .tx_data_req(tx_data_req), .tx_in_header(tx_in_header), .qpsk_rate(qpsk_rate),
    .rx_len_valid(rx_len_valid), .rx_len(rx_len), .rx_to_acq(rx_to_acq), .ref_up(ref_up),
    .ref_down(ref_down), .adc_ref(adc_ref));

// ---- verification/tb_top.sv ----
// Self-checking bench for the modem frame configuration block.
`timescale 1ns/100ps
module tb_top;
    import modem_cfg_pkg::*;
    // --------------------
    // Stimulus and checks
    // --------------------
    logic        clk_sys = 1'b0;
    logic        sys_rst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic        tx_enable = 1'b0;
    logic        acq_done = 1'b0;
    logic        sfd_found = 1'b0;
    logic        rx_len_valid = 1'b0;
    logic [15:0] rx_len = 16'h0000;
    logic        ref_up = 1'b0;
    logic        ref_down = 1'b0;
    logic        rx_dqpsk = 1'b0;
    logic        run = 1'b0;
    logic        bclk;
    logic        pready, pslverr, tx_data_req, tx_in_header, qpsk_rate, rx_to_acq;
    logic [31:0] prdata;
    logic [5:0]  adc_ref;
    int          edges;
    int          err_total = 0;
    int          checks = 0;

    always #4 clk_sys = ~clk_sys;

    modem_frame_config_ab i_dut (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
        .transmit_bit_clock(bclk), .receive_bit_clock(bclk), .tx_enable(tx_enable),
        .tx_data_req(tx_data_req), .tx_in_header(tx_in_header), .qpsk_rate(qpsk_rate),
        .acq_done(acq_done), .sfd_found(sfd_found), .rx_len_valid(rx_len_valid), .rx_len(rx_len),
        .rx_dqpsk(rx_dqpsk), .rx_to_acq(rx_to_acq), .ref_up(ref_up), .ref_down(ref_down), .adc_ref(adc_ref));
    bit_clock_host_model i_host (.run(run), .bclk(bclk), .edges(edges));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        apb(1'b1, a, d, q, e);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic eexp);
        logic [31:0] q;
        logic        e;
        apb(1'b0, a, 32'h0, q, e);
        check(q, exp);
        check({31'h0, e}, {31'h0, eexp});
    endtask

    task automatic do_reset;
        sys_rst <= 1'b1;
        repeat (3) @(posedge clk_sys);
        sys_rst <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic test_regs;
        rd_chk(OFS_CONFIG_A, 32'h0, 1'b0);
        rd_chk(OFS_CONFIG_B, 32'h0, 1'b0);
        rd_chk(OFS_STATUS, 32'h0000_2001, 1'b0);
        wr(OFS_CONFIG_A, 32'hFFFF_FFFF);
        rd_chk(OFS_CONFIG_A, 32'h0000_001E, 1'b0);
        wr(OFS_CONFIG_B, 32'h0000_007C);
        rd_chk(OFS_CONFIG_B, 32'h0000_007C, 1'b0);
        wr(8'h0C, 32'h0000_00FF);
        rd_chk(8'h0C, 32'h0, 1'b1);
    endtask

    task automatic tx_frame(input logic [1:0] m, input logic [4:0] n, input logic cr);
        int hb;
        int k;
        hb = (int'(PREAMBLE_BITS) + int'(SFD_BITS) + 16 * int'(m)) << cr;
        wr(OFS_CONFIG_A, {27'h0, m, 3'h0});
        wr(OFS_CONFIG_B, {24'h0, cr, n, 2'h0});
        tx_enable <= 1'b1;
        run <= 1'b1;
        for (k = 0; k < 5000 && tx_data_req !== 1'b1; k++) @(negedge clk_sys);
        check(edges, hb - int'(n));
        for (k = 0; k < 500 && tx_in_header !== 1'b0; k++) @(negedge clk_sys);
        check(edges, hb);
        check({31'h0, qpsk_rate}, {31'h0, cr});
        @(posedge clk_sys);
        tx_enable <= 1'b0;
        run <= 1'b0;
        repeat (3) @(posedge clk_sys);
    endtask

    task automatic rx_case(input logic [4:0] cfga, input logic sfd, input logic [15:0] len, input int exp);
        int k;
        wr(OFS_CONFIG_A, {27'h0, cfga});
        acq_done <= 1'b1;
        @(posedge clk_sys);
        acq_done <= 1'b0;
        if (sfd) begin
            @(posedge clk_sys);
            sfd_found <= 1'b1;
            @(posedge clk_sys);
            sfd_found <= 1'b0;
            rx_len_valid <= 1'b1;
            rx_len <= len;
            @(posedge clk_sys);
            rx_len_valid <= 1'b0;
        end
        run <= 1'b1;
        for (k = 0; k < 3000 && rx_to_acq !== 1'b1; k++) @(negedge clk_sys);
        check((rx_to_acq === 1'b1) ? edges : -1, exp);
        @(posedge clk_sys);
        run <= 1'b0;
        repeat (3) @(posedge clk_sys);
    endtask

    task automatic test_ref;
        wr(OFS_CONFIG_B, 32'h0);
        ref_up <= 1'b1;
        repeat (4) @(posedge clk_sys);
        ref_up <= 1'b0;
        @(negedge clk_sys);
        check({26'h0, adc_ref}, 32'h24);
        wr(OFS_CONFIG_B, 32'h1);
        ref_up <= 1'b1;
        repeat (4) @(posedge clk_sys);
        ref_up <= 1'b0;
        @(negedge clk_sys);
        check({26'h0, adc_ref}, 32'h24);
        wr(OFS_CONFIG_B, 32'h0);
        ref_down <= 1'b1;
        repeat (2) @(posedge clk_sys);
        ref_down <= 1'b0;
        @(negedge clk_sys);
        check({26'h0, adc_ref}, 32'h22);
        wr(OFS_CONFIG_B, 32'h3);
        repeat (2) @(negedge clk_sys);
        check({26'h0, adc_ref}, 32'h20);
    endtask

    // Without constant rate, the rate follows DQPSK data only in the data state.
    task automatic test_dqpsk;
        wr(OFS_CONFIG_A, 32'h0);
        rx_dqpsk <= 1'b1;
        acq_done <= 1'b1;
        @(posedge clk_sys);
        acq_done <= 1'b0;
        sfd_found <= 1'b1;
        @(posedge clk_sys);
        sfd_found <= 1'b0;
        @(negedge clk_sys);
        check({31'h0, qpsk_rate}, 32'h0);
        @(posedge clk_sys);
        rx_dqpsk <= 1'b0;
        @(negedge clk_sys);
        check({31'h0, qpsk_rate}, 32'h1);
        @(negedge clk_sys);
        check({31'h0, qpsk_rate}, 32'h0);
        @(posedge clk_sys);
        do_reset;
    endtask

    initial begin
        do_reset;
        test_regs;
        tx_frame(2'h0, 5'h00, 1'b0);
        tx_frame(2'h1, 5'h1F, 1'b0);
        tx_frame(2'h2, 5'h05, 1'b0);
        tx_frame(2'h3, 5'h11, 1'b0);
        tx_frame(2'h0, 5'h03, 1'b1);
        rx_case(5'h00, 1'b1, 16'h0000, 0);
        rx_case(5'h12, 1'b1, 16'h0003, 3);
        rx_case(5'h1A, 1'b1, 16'h0005, 5);
        rx_case(5'h04, 1'b0, 16'h0000, 256);
        rx_case(5'h0A, 1'b1, 16'h0003, -1);
        do_reset;
        test_ref;
        test_dqpsk;
        rx_case(5'h00, 1'b0, 16'h0000, -1);
        tally_and_finish;
    end

    initial begin
        #400000;
        err_total++;
        tally_and_finish;
    end
endmodule
